// ==== logic/nav_codec_defs.svh ====
// Constants of the navigation serial record codec
// Summary of operation
// - Self-test item is 28 ASCII bytes: four flags, status word, five chips.
// - First flag byte bits 0-6: database, battery, user data, receiver, serial.
// - Second flag byte bits 0-6: loader, bus, displays, air data, lamps.
// - Third byte: three lamp/superflag faults; fourth unused; bit 7 always one.
// - A four-character receiver error status word follows the flag bytes.
// - Five four-character chip designators follow, one per memory or processor.
// - Each active route waypoint gets an item with all its fields.
// - Waypoints beyond a fence are omitted while active precedes the fence.
// - Arc waypoints omitted before reaching arc end; earlier ones after passing.
// - Route designator is w and a two-digit index 01 to 99.
// - At most 32 waypoint items per route transmission.
// - Byte 1: sequence in bits 4-0, active bit 5, last bit 6.
// - Bytes 2-6 identifier; 7FH in byte 2 marks it unknown.
// - Bytes 7-9 latitude: sign, degrees, minutes, hundredths packed.
// - 7FH in byte 7 marks position unavailable; bytes 7-13 ignored.
// - Bytes 10-13 longitude: sign, degrees, minutes, hundredths.
// - Bytes 14-15 magnetic variation, two's complement sixteenths, east positive.
// - 7FH in byte 14 marks variation unavailable.
// - No route items while the active route is invalid.
// - Route item set repeats every 2 s, within half a second.
// - Fuel record: 13 bytes, 02H, unit, digits and checks, dashes invalid.
// - Check digit is low decimal digit of the sum of four digits.
// - Serial bytes at 9600 baud, start, eight data LSB first, stop.
// - Frame opens with STX, closes with ETX; items end with CR.
`ifndef NAV_CODEC_DEFS_SVH
`define NAV_CODEC_DEFS_SVH
`define CLK_HZ           100000000
`define BAUD_RATE        9600
`define BIT_CYC          (`CLK_HZ / `BAUD_RATE)
`define ROUTE_PERIOD_MS  2000
`define ROUTE_PERIOD_CYC (`ROUTE_PERIOD_MS * (`CLK_HZ / 1000))
`define CH_STX           8'h02
`define CH_ETX           8'h03
`define CH_CR            8'h0D
`define CH_SELF          8'h75
`define CH_ROUTE         8'h77
`define CH_DASH          8'h2D
`define CH_ZERO          8'h30
`define CH_UNAVAIL       8'h7F
`define FLAG_TOP         8'h80
`define SELF_LAST        8'h1D
`define ITEM_LAST        8'h12
`define MAX_ITEMS        6'h20
`define REC_LAST         4'hC
`define NO_INDEX         6'h3F
`endif

// ==== logic/nav_codec_pkg.sv ====
// Types shared by the codec modules
package nav_codec_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_STX   = 6'h02,
      ST_SELF  = 6'h04,
      ST_WSCAN = 6'h08,
      ST_WITEM = 6'h10,
      ST_ETX   = 6'h20
   } frm_state_type;
endpackage

// ==== logic/byte_skid_buffer.sv ====
// Two-entry byte buffer between formatter and transmitter
`timescale 1ns/10ps
`default_nettype none
module byte_skid_buffer
   import nav_codec_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_ok,
   input  wire logic       i_in_valid,
   input  wire logic [7:0] i_in_data,
   output logic            o_in_ready,
   output logic            o_out_valid,
   output logic [7:0]      o_out_data,
   input  wire logic       i_out_ready
);
   typedef struct packed {
      logic [7:0] head;
      logic [7:0] tail;
      logic [1:0] cnt;
   } buf_type;
   buf_type r_ff, nxt_r;
   logic    push, pop;

   // Ready derives from the count alone, so no path from the drain side
   assign o_in_ready  = (r_ff.cnt != 2'h2);
   assign o_out_valid = (r_ff.cnt != 2'h0);
   assign o_out_data  = r_ff.head;
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Head always holds the oldest word
   always_comb begin
      nxt_r = r_ff;
      if (pop) begin
         nxt_r.head = r_ff.tail;
      end
      if (push) begin
         if (r_ff.cnt == 2'h0 || (r_ff.cnt == 2'h1 && pop)) begin
            nxt_r.head = i_in_data;
         end else begin
            nxt_r.tail = i_in_data;
         end
      end
      nxt_r.cnt = r_ff.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge i_core_clk or negedge i_rst_ok) begin
      if (!i_rst_ok) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   a_buf_bound: assert property (@(posedge i_core_clk) disable iff (!i_rst_ok)
      r_ff.cnt != 2'h3) else $error("buffer count overflow");
endmodule
`default_nettype wire

// ==== logic/nav_serial_record_codec.sv ====
// Route/self-test record framer, serial link and fuel record checker
`timescale 1ns/10ps
`default_nettype none
`include "nav_codec_defs.svh"
module nav_serial_record_codec
   import nav_codec_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `ROUTE_PERIOD_CYC,
   parameter int unsigned BIT_CYC    = `BIT_CYC
)(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic [6:0]   i_fault_sys,
   input  wire logic [6:0]   i_fault_io,
   input  wire logic [2:0]   i_fault_lamp,
   input  wire logic [15:0]  i_satellite_receiver_status,
   input  wire logic [79:0]  i_chip_desig,
   input  wire logic         i_wpt_wr,
   input  wire logic [4:0]   i_wpt_addr,
   input  wire logic [39:0]  i_wpt_ident,
   input  wire logic         i_wpt_ident_ok,
   input  wire logic         i_wpt_lat_s,
   input  wire logic [6:0]   i_wpt_lat_deg,
   input  wire logic [5:0]   i_wpt_lat_min,
   input  wire logic [6:0]   i_wpt_lat_hun,
   input  wire logic         i_wpt_lon_w,
   input  wire logic [6:0]   i_wpt_lon_deg,
   input  wire logic [5:0]   i_wpt_lon_min,
   input  wire logic [6:0]   i_wpt_lon_hun,
   input  wire logic         i_wpt_pos_ok,
   input  wire logic [15:0]  i_wpt_magvar,
   input  wire logic         i_wpt_magvar_ok,
   input  wire logic         i_route_valid,
   input  wire logic [5:0]   i_route_count,
   input  wire logic [4:0]   i_active_idx,
   input  wire logic [5:0]   i_fence_idx,
   input  wire logic [5:0]   i_arc_start_idx,
   input  wire logic [5:0]   i_arc_end_idx,
   input  wire logic         i_rxd,
   output logic              o_txd,
   output logic              o_fuel_stb,
   output logic [7:0]        o_fuel_unit,
   output logic [15:0]       o_fuel_rem,
   output logic              o_fuel_rem_ok,
   output logic [15:0]       o_fuel_flow,
   output logic              o_fuel_flow_ok,
   output logic              o_fuel_err
);
   typedef struct packed {
      frm_state_type st;
      logic [7:0]    bidx;
      logic [5:0]    waypoint_lamp;
      logic [5:0]    items;
      logic [27:0]   per_cnt;
      logic [13:0]   tx_cnt;
      logic [3:0]    tx_bit;
      logic [9:0]    tx_sh;
      logic          tx_busy;
      logic          txd;
      logic [1:0]    rx_sync;
      logic [13:0]   rx_cnt;
      logic [3:0]    rx_bit;
      logic [7:0]    rx_sh;
      logic          rx_busy;
      logic [3:0]    ridx;
      logic [7:0]    unit;
      logic [15:0]   rem;
      logic [15:0]   flow;
      logic          rem_bad;
      logic          flow_bad;
      logic          stb;
      logic [7:0]    unit_o;
      logic [15:0]   rem_o;
      logic          rem_ok_o;
      logic [15:0]   flow_o;
      logic          flow_ok_o;
      logic          err;
   } core_type;
   localparam int ENT_W = 115;

   core_type         r_ff, nxt_r;
   logic             rst_meta_ff, rst_ok;
   logic [ENT_W-1:0] wpt_mem [0:31];
   logic [ENT_W-1:0] ent;
   logic [7:0]       fmt_byte;
   logic             fmt_valid, buf_ready, out_valid, out_ready, push_ok;
   logic [7:0]       out_data, rxb;
   logic             rx_done;

   // ASCII hex character of a nibble
   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Low decimal digit of the sum of four BCD digits
   function automatic logic [3:0] bcd_chk(input logic [15:0] v);
      logic [5:0] s;
      s = {2'h0, v[3:0]} + {2'h0, v[7:4]} + {2'h0, v[11:8]}
          + {2'h0, v[15:12]};
      bcd_chk = 4'(s % 6'h0A);
   endfunction

   function automatic logic is_digit(input logic [7:0] b);
      is_digit = (b >= 8'h30) && (b <= 8'h39);
   endfunction

   // Route fence and arc suppression of one waypoint index
   function automatic logic omitted(input logic [5:0] i);
      logic [5:0] a;
      a = {1'b0, i_active_idx};
      omitted = 1'b0;
      if (i_fence_idx != `NO_INDEX && a < i_fence_idx && i > i_fence_idx)
         omitted = 1'b1;
      if (i_arc_start_idx != `NO_INDEX) begin
         if (a < i_arc_end_idx && i > i_arc_start_idx)
            omitted = 1'b1;
         if (a > i_arc_end_idx && i < i_arc_end_idx)
            omitted = 1'b1;
      end
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_ok      <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_ok      <= rst_meta_ff;
      end
   end

   // Route store, positions packed on write so reads are plain bytes
   always_ff @(posedge i_core_clk) begin
      if (i_wpt_wr) begin
         wpt_mem[i_wpt_addr] <= {i_wpt_ident_ok, i_wpt_pos_ok,
            i_wpt_magvar_ok, i_wpt_ident,
            i_wpt_lat_s, i_wpt_lat_deg, 2'h0, i_wpt_lat_min,
            1'b0, i_wpt_lat_hun,
            i_wpt_lon_w, 7'h00, 1'b0, i_wpt_lon_deg, 2'h0, i_wpt_lon_min,
            1'b0, i_wpt_lon_hun,
            i_wpt_magvar};
      end
   end
   assign ent = wpt_mem[r_ff.waypoint_lamp[4:0]];

   // Byte that the formatter offers in the current state
   always_comb begin
      logic [5:0] n;
      n = r_ff.items + 6'h01;
      fmt_byte  = `CH_CR;
      fmt_valid = 1'b1;
      case (r_ff.st)
         ST_STX:  fmt_byte = `CH_STX;
         ST_ETX:  fmt_byte = `CH_ETX;
         ST_SELF: begin
            if (r_ff.bidx == 8'h00) fmt_byte = `CH_SELF;
            else if (r_ff.bidx == 8'h01)
               fmt_byte = `FLAG_TOP | {1'b0, i_fault_sys};
            else if (r_ff.bidx == 8'h02)
               fmt_byte = `FLAG_TOP | {1'b0, i_fault_io};
            else if (r_ff.bidx == 8'h03)
               fmt_byte = `FLAG_TOP | {5'h00, i_fault_lamp};
            else if (r_ff.bidx == 8'h04) fmt_byte = `FLAG_TOP;
            else if (r_ff.bidx < 8'h09)
               fmt_byte = hex_ch(i_satellite_receiver_status[4'hF - 4*(r_ff.bidx - 5) -: 4]);
            else if (r_ff.bidx < `SELF_LAST)
               fmt_byte = hex_ch(i_chip_desig[7'h4F - 4*(r_ff.bidx - 9) -: 4]);
         end
         ST_WITEM: begin
            case (r_ff.bidx)
               8'h00: fmt_byte = `CH_ROUTE;
               8'h01: fmt_byte = `CH_ZERO + {4'h0, 4'(n / 6'd10)};
               8'h02: fmt_byte = `CH_ZERO + {4'h0, 4'(n % 6'd10)};
               8'h03: fmt_byte = {1'b0, r_ff.waypoint_lamp == i_route_count - 6'h01,
                  r_ff.waypoint_lamp[4:0] == i_active_idx, r_ff.waypoint_lamp[4:0]};
               8'h04: fmt_byte = ent[114] ? ent[111:104] : `CH_UNAVAIL;
               8'h05, 8'h06, 8'h07, 8'h08:
                  fmt_byte = ent[111 - 8*(r_ff.bidx - 4) -: 8];
               8'h09: fmt_byte = ent[113] ? ent[71:64] : `CH_UNAVAIL;
               8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
                  fmt_byte = ent[113] ? ent[71 - 8*(r_ff.bidx - 9) -: 8]
                                      : 8'h00;
               8'h10: fmt_byte = ent[112] ? ent[15:8] : `CH_UNAVAIL;
               8'h11: fmt_byte = ent[112] ? ent[7:0] : 8'h00;
               default: fmt_byte = `CH_CR;
            endcase
         end
         default: fmt_valid = 1'b0;
      endcase
   end
   assign push_ok = fmt_valid && buf_ready;
   assign rxb     = r_ff.rx_sh;

   // Next state of framer, transmitter, receiver and record checker
   always_comb begin
      nxt_r     = r_ff;
      nxt_r.stb = 1'b0;
      nxt_r.err = 1'b0;
      rx_done   = 1'b0;
      // Frame timer wraps every period; an idle framer starts a frame when it wraps to zero
      nxt_r.per_cnt = r_ff.per_cnt + 28'h1;
      if (r_ff.per_cnt == 28'(PERIOD_CYC - 1)) begin
         nxt_r.per_cnt = '0;
      end
      case (r_ff.st)
         ST_IDLE: if (r_ff.per_cnt == '0) nxt_r.st = ST_STX;
         ST_STX: if (push_ok) begin
            nxt_r.st   = ST_SELF;
            nxt_r.bidx = '0;
         end
         ST_SELF: if (push_ok) begin
            nxt_r.bidx = r_ff.bidx + 8'h1;
            if (r_ff.bidx == `SELF_LAST) begin
               nxt_r.st    = ST_WSCAN;
               nxt_r.waypoint_lamp   = '0;
               nxt_r.items = '0;
            end
         end
         ST_WSCAN: begin
            // Invalid route or the cap ends the route part at once
            if (!i_route_valid || r_ff.items == `MAX_ITEMS ||
                r_ff.waypoint_lamp >= i_route_count || r_ff.waypoint_lamp[5]) begin
               nxt_r.st = ST_ETX;
            end else if (omitted(r_ff.waypoint_lamp)) begin
               nxt_r.waypoint_lamp = r_ff.waypoint_lamp + 6'h1;
            end else begin
               nxt_r.st   = ST_WITEM;
               nxt_r.bidx = '0;
            end
         end
         ST_WITEM: if (push_ok) begin
            nxt_r.bidx = r_ff.bidx + 8'h1;
            if (r_ff.bidx == `ITEM_LAST) begin
               nxt_r.st    = ST_WSCAN;
               nxt_r.waypoint_lamp   = r_ff.waypoint_lamp + 6'h1;
               nxt_r.items = r_ff.items + 6'h1;
            end
         end
         ST_ETX: if (push_ok) nxt_r.st = ST_IDLE;
         default: nxt_r.st = ST_IDLE;
      endcase
      // Transmitter: start low, data LSB first, stop high
      if (!r_ff.tx_busy) begin
         if (out_valid) begin
            nxt_r.tx_sh   = {1'b1, out_data, 1'b0};
            nxt_r.txd     = 1'b0;
            nxt_r.tx_busy = 1'b1;
            nxt_r.tx_cnt  = '0;
            nxt_r.tx_bit  = '0;
         end
      end else if (r_ff.tx_cnt == 14'(BIT_CYC - 1)) begin
         nxt_r.tx_cnt = '0;
         nxt_r.tx_bit = r_ff.tx_bit + 4'h1;
         nxt_r.tx_sh  = {1'b1, r_ff.tx_sh[9:1]};
         nxt_r.txd    = r_ff.tx_sh[1];
         if (r_ff.tx_bit == 4'h9) begin
            nxt_r.tx_busy = 1'b0;
            nxt_r.txd     = 1'b1;
         end
      end else begin
         nxt_r.tx_cnt = r_ff.tx_cnt + 14'h1;
      end
      // Receiver samples mid-bit off the second synchroniser flop
      nxt_r.rx_sync = {r_ff.rx_sync[0], i_rxd};
      if (!r_ff.rx_busy) begin
         if (!r_ff.rx_sync[1]) begin
            nxt_r.rx_busy = 1'b1;
            nxt_r.rx_cnt  = 14'(BIT_CYC / 2);
            nxt_r.rx_bit  = '0;
         end
      end else if (r_ff.rx_cnt == 14'(BIT_CYC - 1)) begin
         nxt_r.rx_cnt = '0;
         nxt_r.rx_bit = r_ff.rx_bit + 4'h1;
         if (r_ff.rx_bit == 4'h0 && r_ff.rx_sync[1]) begin
            nxt_r.rx_busy = 1'b0; // Glitch, not a start bit
         end else if (r_ff.rx_bit < 4'h9 && r_ff.rx_bit != 4'h0) begin
            nxt_r.rx_sh = {r_ff.rx_sync[1], r_ff.rx_sh[7:1]};
         end else if (r_ff.rx_bit == 4'h9) begin
            nxt_r.rx_busy = 1'b0;
            rx_done       = r_ff.rx_sync[1];
            nxt_r.err     = !r_ff.rx_sync[1];
            if (!r_ff.rx_sync[1]) nxt_r.ridx = '0;
         end
      end else begin
         nxt_r.rx_cnt = r_ff.rx_cnt + 14'h1;
      end
      // Fuel record walk; a bad digit flags its field, a wrong opener or closer drops the record
      if (rx_done) begin
         nxt_r.ridx = r_ff.ridx + 4'h1;
         case (r_ff.ridx)
            4'h0: if (rxb != `CH_STX) nxt_r.ridx = '0;
            4'h1: begin
               nxt_r.unit     = rxb;
               nxt_r.rem_bad  = 1'b0;
               nxt_r.flow_bad = 1'b0;
            end
            4'h2, 4'h3, 4'h4, 4'h5: begin
               nxt_r.rem = {rxb[3:0], r_ff.rem[15:4]};
               if (!is_digit(rxb)) nxt_r.rem_bad = 1'b1;
            end
            4'h6: if (!is_digit(rxb) || rxb[3:0] != bcd_chk(r_ff.rem))
               nxt_r.rem_bad = 1'b1;
            4'h7, 4'h8, 4'h9, 4'hA: begin
               nxt_r.flow = {rxb[3:0], r_ff.flow[15:4]};
               if (!is_digit(rxb)) nxt_r.flow_bad = 1'b1;
            end
            4'hB: if (!is_digit(rxb) || rxb[3:0] != bcd_chk(r_ff.flow))
               nxt_r.flow_bad = 1'b1;
            default: begin
               nxt_r.ridx = '0;
               if (rxb == `CH_ETX) begin
                  nxt_r.stb       = 1'b1;
                  nxt_r.unit_o    = r_ff.unit;
                  nxt_r.rem_o     = r_ff.rem;
                  nxt_r.rem_ok_o  = !r_ff.rem_bad;
                  nxt_r.flow_o    = r_ff.flow;
                  nxt_r.flow_ok_o = !r_ff.flow_bad;
               end else begin
                  nxt_r.err = 1'b1;
               end
            end
         endcase
      end
   end

   // Whole state in one register; line idles high
   always_ff @(posedge i_core_clk or negedge rst_ok) begin
      if (!rst_ok) begin
         r_ff         <= '0;
         r_ff.st      <= ST_IDLE;
         r_ff.per_cnt <= 28'h1;
         r_ff.txd     <= 1'b1;
         r_ff.rx_sync <= 2'h3;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Buffer absorbs transmitter stalls so no formatted byte is lost
   byte_skid_buffer u_buf (
      .i_core_clk  (i_core_clk),
      .i_rst_ok    (rst_ok),
      .i_in_valid  (fmt_valid),
      .i_in_data   (fmt_byte),
      .o_in_ready  (buf_ready),
      .o_out_valid (out_valid),
      .o_out_data  (out_data),
      .i_out_ready (out_ready)
   );
   assign out_ready = !r_ff.tx_busy;

   assign o_txd          = r_ff.txd;
   assign o_fuel_stb     = r_ff.stb;
   assign o_fuel_unit    = r_ff.unit_o;
   assign o_fuel_rem     = r_ff.rem_o;
   assign o_fuel_rem_ok  = r_ff.rem_ok_o;
   assign o_fuel_flow    = r_ff.flow_o;
   assign o_fuel_flow_ok = r_ff.flow_ok_o;
   assign o_fuel_err     = r_ff.err;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_ok);
   a_self_length: assert property ((r_ff.st == ST_SELF && push_ok
      && r_ff.bidx == `SELF_LAST) |=> r_ff.st == ST_WSCAN)
      else $error("self-test item length wrong");
   a_flag_top_bit: assert property ((r_ff.st == ST_SELF && r_ff.bidx > 8'h0
      && r_ff.bidx < 8'h05) |-> fmt_byte[7])
      else $error("flag byte bit 7 clear");
   a_item_cap: assert property (r_ff.items <= `MAX_ITEMS)
      else $error("too many route items");
   a_route_invalid: assert property ((r_ff.st == ST_WSCAN &&
      !i_route_valid) |=> r_ff.st == ST_ETX)
      else $error("route item sent for invalid route");
   a_item_end: assert property ((r_ff.st == ST_WITEM && push_ok
      && r_ff.bidx == `ITEM_LAST) |-> fmt_byte == `CH_CR ##1
      r_ff.st == ST_WSCAN) else $error("route item not closed by CR");
   a_push_hold: assert property ((fmt_valid && !buf_ready) |=>
      fmt_valid && $stable(r_ff.st) && $stable(r_ff.bidx))
      else $error("formatter moved while stalled");
   a_start_bit: assert property ($rose(r_ff.tx_busy) |-> !r_ff.txd
      [*8]) else $error("start bit not low");
   a_stop_bit: assert property ((r_ff.tx_busy && r_ff.tx_bit == 4'h9)
      |-> r_ff.txd) else $error("stop bit not high");
   a_period_wrap: assert property (r_ff.per_cnt < 28'(PERIOD_CYC))
      else $error("frame timer out of range");
   a_record_end: assert property (r_ff.stb |-> $past(r_ff.ridx) ==
      `REC_LAST) else $error("fuel record accepted at wrong length");
endmodule
`default_nettype wire

// ==== tb/serial_link_partner.sv ====
// Far-side serial partner: decodes frames and sends fuel records
`timescale 1ns/10ps
`default_nettype none
module serial_link_partner #(
   parameter int BIT_CYC = 16
)(
   input  wire logic       i_core_clk,
   input  wire logic       i_txd,
   output logic            o_rxd,
   output logic            o_got,
   output logic [7:0]      o_byte
);
   initial begin
      o_rxd = 1'b1;
      o_got = 1'b0;
      o_byte = 8'h00;
   end
   // Mid-cell sampling; a low stop bit drops the byte so it shows as missing
   always begin
      @(negedge i_txd);
      repeat (BIT_CYC / 2) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge i_core_clk);
         o_byte[i] = i_txd;
      end
      repeat (BIT_CYC) @(posedge i_core_clk);
      o_got = i_txd;
      @(posedge i_core_clk);
      o_got = 1'b0;
   end
   // Start, eight data bits LSB first, stop; line rests high
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_core_clk);
         #1 o_rxd = f[i];
         repeat (BIT_CYC - 1) @(posedge i_core_clk);
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/nav_serial_record_codec_tb.sv ====
// Bench for the record codec: self-test and route frames, fuel input
`timescale 1ns/10ps
`default_nettype none
module nav_serial_record_codec_tb;
   typedef struct {logic err, rok, fok; logic [15:0] rem, flow;} fuel_type;
   logic clk = 1'b0, rst_n = 1'b0, wr, idok, lat_s, lon_w, pok, mok, rv;
   logic [6:0]  f_sys, f_io, lat_deg, lat_hun, lon_deg, lon_hun;
   logic [5:0]  lat_min, lon_min, cnt, fence, arc_s, arc_e;
   logic [4:0]  addr, act;
   logic [2:0]  f_lamp;
   logic [95:0] big, wv;
   logic [15:0] mag, rem, flow;
   logic [7:0]  rx_byte, unit, wb [0:2][0:13], q[$];
   logic txd, rxd, got, stb, ferr, rok, fok;
   fuel_type fq[$];
   int seed, errors = 0, cmp_count = 0;
   always #5 clk = ~clk;
   nav_serial_record_codec #(.PERIOD_CYC(20000), .BIT_CYC(16)) dut (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_fault_sys(f_sys),
      .i_fault_io(f_io), .i_fault_lamp(f_lamp), .i_satellite_receiver_status(big[95:80]),
      .i_chip_desig(big[79:0]), .i_wpt_wr(wr), .i_wpt_addr(addr),
      .i_wpt_ident(wv[39:0]), .i_wpt_ident_ok(idok), .i_wpt_lat_s(lat_s),
      .i_wpt_lat_deg(lat_deg), .i_wpt_lat_min(lat_min),
      .i_wpt_lat_hun(lat_hun), .i_wpt_lon_w(lon_w), .i_wpt_lon_deg(lon_deg),
      .i_wpt_lon_min(lon_min), .i_wpt_lon_hun(lon_hun), .i_wpt_pos_ok(pok),
      .i_wpt_magvar(mag), .i_wpt_magvar_ok(mok), .i_route_valid(rv),
      .i_route_count(cnt), .i_active_idx(act), .i_fence_idx(fence),
      .i_arc_start_idx(arc_s), .i_arc_end_idx(arc_e), .i_rxd(rxd),
      .o_txd(txd), .o_fuel_stb(stb), .o_fuel_unit(unit), .o_fuel_rem(rem),
      .o_fuel_rem_ok(rok), .o_fuel_flow(flow), .o_fuel_flow_ok(fok),
      .o_fuel_err(ferr));
   serial_link_partner #(.BIT_CYC(16)) partner (.i_core_clk(clk),
      .i_txd(txd), .o_rxd(rxd), .o_got(got), .o_byte(rx_byte));
   task automatic chk(input string nm, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Every byte seen on the line is matched against the oldest note
   always @(posedge got) begin
      if (q.size() == 0) chk("stray byte", 16'h0, {8'h0, rx_byte});
      else chk("tx byte", {8'h0, q.pop_front()}, {8'h0, rx_byte});
   end
   // Fuel outputs sampled mid-cycle, where they are settled
   always @(negedge clk) if (stb === 1'b1 || ferr === 1'b1) begin
      fuel_type e;
      e = fq.pop_front();
      chk("fuel err", {15'h0, e.err}, {15'h0, ferr});
      if (!e.err) begin
         chk("unit", 16'h47, {8'h0, unit});
         chk("rem ok", {15'h0, e.rok}, {15'h0, rok});
         chk("flow ok", {15'h0, e.fok}, {15'h0, fok});
         if (e.rok) chk("rem", e.rem, rem);
         if (e.fok) chk("flow", e.flow, flow);
      end
   end
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   function automatic logic [3:0] ck(input logic [15:0] v);
      return 4'((int'(v[3:0]) + v[7:4] + v[11:8] + v[15:12]) % 10);
   endfunction
   task automatic wr_wpt(input int a);
      @(posedge clk);
      #1 {idok, pok, mok} = {a != 1, a != 2, a != 0};
      wv = {$random(seed), $random(seed), $random(seed)};
      {lat_s, lat_deg, lat_min, lat_hun, lon_w, lon_deg} = wv[68:40];
      {lon_min, lon_hun, mag} = wv[95:67];
      addr = 5'(a);
      wr = 1'b1;
      wb[a][0] = idok ? wv[39:32] : 8'h7F;
      for (int i = 1; i < 5; i++) wb[a][i] = wv[39-8*i -: 8];
      wb[a][5] = pok ? {lat_s, lat_deg} : 8'h7F;
      wb[a][6] = pok ? {2'h0, lat_min} : 8'h00;
      wb[a][7] = pok ? {1'h0, lat_hun} : 8'h00;
      wb[a][8] = pok ? {lon_w, 7'h0} : 8'h00;
      wb[a][9] = pok ? {1'h0, lon_deg} : 8'h00;
      wb[a][10] = pok ? {2'h0, lon_min} : 8'h00;
      wb[a][11] = pok ? {1'h0, lon_hun} : 8'h00;
      wb[a][12] = mok ? mag[15:8] : 8'h7F;
      wb[a][13] = mok ? mag[7:0] : 8'h00;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask
   // Expected frame from the rules and the route settings now applied
   task automatic push_frame;
      int m;
      m = 0;
      q.push_back(8'h02);
      q.push_back(8'h75);
      q.push_back({1'b1, f_sys});
      q.push_back({1'b1, f_io});
      q.push_back({5'h10, f_lamp});
      q.push_back(8'h80);
      for (int i = 23; i >= 0; i--) q.push_back(hx(big[4*i +: 4]));
      q.push_back(8'h0D);
      for (int k = 0; k < cnt && rv; k++) begin
         if (fence != 6'h3F && act < fence && k > fence) continue;
         if (arc_s != 6'h3F && act < arc_e && k > arc_s) continue;
         if (arc_s != 6'h3F && act > arc_e && k < arc_e) continue;
         m++;
         q.push_back(8'h77);
         q.push_back(8'h30);
         q.push_back(8'(8'h30 + m));
         q.push_back({1'b0, k == cnt - 1, k == act, 5'(k)});
         for (int j = 0; j < 14; j++) q.push_back(wb[k][j]);
         q.push_back(8'h0D);
      end
      q.push_back(8'h03);
   endtask
   task automatic wait_q;
      int n;
      n = 0;
      while ((q.size() != 0 || fq.size() != 0) && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40000) begin
         errors++;
         $display("CHECK FAILED drain expected 0 seen %0d", q.size());
         results();
      end
   endtask
   // Record kinds: dashed flow digit, bad remaining check, bad closer
   task automatic send_rec(input int r);
      fuel_type e;
      logic [31:0] x;
      x = $random(seed);
      for (int i = 0; i < 8; i++) x[4*i +: 4] = 4'(x[4*i +: 4] % 10);
      {e.flow, e.rem} = x;
      e.err = (r == 2);
      e.rok = (r != 1);
      e.fok = (r != 0);
      fq.push_back(e);
      partner.send_byte(8'h02);
      partner.send_byte(8'h47);
      for (int i = 0; i < 4; i++) partner.send_byte({4'h3, e.rem[4*i +: 4]});
      partner.send_byte({4'h3, ck(e.rem) ^ 4'(r == 1)});
      for (int i = 0; i < 4; i++) partner.send_byte((r == 0 && i == 2) ?
         8'h2D : {4'h3, e.flow[4*i +: 4]});
      partner.send_byte({4'h3, ck(e.flow)});
      partner.send_byte(r == 2 ? 8'h04 : 8'h03);
   endtask
   initial begin
      seed = 94605;
      {wr, addr, wv, mag, big, f_sys, f_io, f_lamp} = '0;
      {idok, pok, mok, lat_s, lon_w, lat_deg, lat_min, lat_hun} = '0;
      {lon_deg, lon_min, lon_hun} = '0;
      {rv, cnt, act, fence, arc_s, arc_e} = {1'b1, 6'h03, 5'h0, 6'h01,
         6'h3F, 6'h3F};
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 big = {$random(seed), $random(seed), $random(seed)};
      {f_sys, f_io, f_lamp} = 17'($random(seed));
      for (int a = 0; a < 3; a++) wr_wpt(a);
      push_frame();
      wait_q();
      $display("test fenced route done");
      #1 {fence, act} = {6'h3F, 5'h02};
      push_frame();
      wait_q();
      $display("test full route done");
      #1 {arc_s, arc_e} = {6'h00, 6'h01};
      push_frame();
      wait_q();
      $display("test arc route done");
      #1 rv = 1'b0;
      push_frame();
      wait_q();
      $display("test invalid route done");
      for (int r = 0; r < 3; r++) send_rec(r);
      wait_q();
      $display("test fuel records done");
      results();
   end
endmodule
`default_nettype wire
